// ---- common/sfc_pkg.sv ----
// Shared constants for the serial flash command host controller
package sfc_pkg;
  // Opcodes
  localparam logic [7:0] OP_LATCH_SET = 8'h06;
  localparam logic [7:0] OP_LATCH_CLR = 8'h04;
  localparam logic [7:0] OP_VOL_WRITE_LATCH_SET_CMD = 8'h50;
  localparam logic [7:0] OP_STAT_LO = 8'h05;
  localparam logic [7:0] OP_STAT_HI = 8'h35;
  localparam logic [7:0] OP_CNT_WRITE = 8'h9b;
  localparam logic [7:0] OP_CNT_READ = 8'h96;
  localparam logic [7:0] CNT_RSVD_BYTE = 8'h00;
  localparam logic [7:0] CNT_TYPE_KEY = 8'h01;
  // Security register select codes on address bits 15..10
  localparam logic [5:0] SECREG1 = 6'h04;
  localparam logic [5:0] SECREG2 = 6'h08;
  localparam logic [5:0] SECREG3 = 6'h0c;
  // Status word bit positions
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_PMODE_LO = 7;
  localparam int ST_PMODE_HI = 8;
  localparam int ST_QE = 9;
  localparam int ST_FAIL = 10;
  localparam int ST_SUSP = 15;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  // Lane modes
  localparam logic [1:0] LANE_1 = 2'h0;
  localparam logic [1:0] LANE_2 = 2'h1;
  localparam logic [1:0] LANE_4 = 2'h2;
  // Controller register offsets
  localparam logic [3:0] R_CTRL = 4'h0;
  localparam logic [3:0] R_ADDR = 4'h1;
  localparam logic [3:0] R_TXDATA = 4'h2;
  localparam logic [3:0] R_RXDATA = 4'h3;
  localparam logic [3:0] R_STATUS = 4'h4;
  localparam logic [3:0] R_FLASH_ST = 4'h5;
  // Control word fields
  localparam int C_OP_LSB = 0;
  localparam int C_CNT_LSB = 8;
  localparam int C_LANE_LSB = 16;
  localparam int C_ADDR_EN = 18;
  localparam int C_ADDR4 = 19;
  localparam int C_MODE_EN = 20;
  localparam int C_QPI = 21;
  localparam int C_RD = 22;
  localparam int C_DUMMY_LSB = 24;
  localparam int C_START = 31;
  // Divider: link clock half period in system clocks
  localparam int CLK_HZ = 40000000;
  localparam int SCK_HZ = 5000000;
  localparam int HALF_CYC = CLK_HZ / (2 * SCK_HZ);
endpackage

// ---- hw/sfc_lane_map.sv ----
// Lane packing of one byte onto 1, 2 or 4 data lanes per clock slot
`timescale 1ns/10ps
module sfc_lane_map (
  // Selection
  input wire logic [1:0] lane_i,
  input wire logic [2:0] slot_i,
  input wire logic [7:0] byte_i,
  // Lane values
  output logic [3:0] lanes_o
);
  always_comb
  begin
    lanes_o = 4'h0;
    case (lane_i)
      sfc_pkg::LANE_2:
      begin
        // Pairs from the top: odd bit on lane 1, even on lane 0
        lanes_o[1] = byte_i[3'd7 - {slot_i[1:0], 1'b0}];
        lanes_o[0] = byte_i[3'd6 - {slot_i[1:0], 1'b0}];
      end
      sfc_pkg::LANE_4:
        // Upper nibble first, lane n carries bit n+4 then n
        lanes_o = slot_i[0] ? byte_i[3:0] : byte_i[7:4];
      default:
        lanes_o[0] = byte_i[3'd7 - slot_i];
    endcase
  end
endmodule

// ---- hw/sfc_host.sv ----
// Host controller driving a serial multi-lane flash over its pins
`timescale 1ns/10ps
module sfc_host #(
  parameter int HALF = sfc_pkg::HALF_CYC,
  parameter int TXLEN = 64
) (
  // System
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register port
  input wire logic [3:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  // Flash pins
  output logic CS_B_O,
  output logic SCK_O,
  input wire logic [3:0] IO_I,
  output logic [3:0] IO_O,
  output logic [3:0] IO_OE_O
);
  typedef enum {SFC_IDLE, SFC_RUN, SFC_GAP} sfc_state_t;

  sfc_state_t state_reg;
  logic [31:0] ctrl_reg, addr_reg, txd_reg, rxd_reg;
  logic [15:0] flash_status_word;
  logic [7:0] div_reg, cnt_reg;
  logic [7:0] cur_byte;
  logic [5:0] byte_reg;
  logic [2:0] slot_reg, slot_max;
  logic [1:0] lane, ph_lane;
  logic [3:0] io_s1, io_s2, lanes;
  logic tick, in_op, in_addr, in_mode, in_dummy, is_rd, sck_reg;
  logic [5:0] addr_bytes;
  logic [7:0] op;
  logic counter_cmd, wlatch_ok;
  logic load_reg, lone_cmd, dummy_en, last_byte, start_req;
  logic [7:0] cnt_last;
  logic [3:0] oe_val;

  // Pin inputs pass two flops
  always_ff @(posedge CLK_I)
  begin
    io_s1 <= IO_I;
    io_s2 <= io_s1;
  end

  assign op = ctrl_reg[sfc_pkg::C_OP_LSB +: 8];
  // Counter commands are forced single lane
  assign counter_cmd = (op == sfc_pkg::OP_CNT_WRITE) ||
                       (op == sfc_pkg::OP_CNT_READ);
  assign lane = counter_cmd ? sfc_pkg::LANE_1 :
                ctrl_reg[sfc_pkg::C_LANE_LSB +: 2];
  assign addr_bytes = ctrl_reg[sfc_pkg::C_ADDR_EN] ?
                      (ctrl_reg[sfc_pkg::C_ADDR4] ? 6'd4 : 6'd3) : 6'd0;
  // Byte positions: opcode, address, mode, dummy, data
  assign in_op = byte_reg == 6'd0;
  assign in_addr = !in_op && (byte_reg <= addr_bytes);
  assign in_mode = ctrl_reg[sfc_pkg::C_MODE_EN] && !counter_cmd &&
                   (byte_reg == addr_bytes + 6'd1);
  assign in_dummy = !in_op && !in_addr && !in_mode &&
                    (cnt_reg == 8'h00) &&
                    (ctrl_reg[sfc_pkg::C_DUMMY_LSB +: 7] != 7'h00);
  assign is_rd = ctrl_reg[sfc_pkg::C_RD];
  // Opcode goes single lane unless four-wire command mode on a non-counter command
  assign ph_lane = in_op ? (ctrl_reg[sfc_pkg::C_QPI] && !counter_cmd ?
                   sfc_pkg::LANE_4 : sfc_pkg::LANE_1) : lane;
  assign slot_max = (ph_lane == sfc_pkg::LANE_4) ? 3'd1 :
                    (ph_lane == sfc_pkg::LANE_2) ? 3'd3 : 3'd7;
  assign start_req = WR_I && ADDR_I == sfc_pkg::R_CTRL &&
                     WDATA_I[sfc_pkg::C_START];
  // Lone opcodes end the frame right after the opcode byte
  assign lone_cmd = (op == sfc_pkg::OP_LATCH_SET) ||
                    (op == sfc_pkg::OP_LATCH_CLR) ||
                    (op == sfc_pkg::OP_VOL_WRITE_LATCH_SET_CMD);
  assign dummy_en = ctrl_reg[sfc_pkg::C_DUMMY_LSB +: 7] != 7'h00;
  // The dummy byte takes count value 0, so data bytes start one higher
  assign cnt_last = ctrl_reg[sfc_pkg::C_CNT_LSB +: 8] + {7'h00, dummy_en};
  assign last_byte = (in_op && lone_cmd) ||
                     (!in_op && !in_addr && !in_mode && !in_dummy &&
                      cnt_reg == cnt_last);
  // Lanes are released while the flash answers a read
  assign oe_val = (is_rd && !in_op && !in_addr && !in_mode) ? 4'h0 :
                  (ph_lane == sfc_pkg::LANE_4) ? 4'hf :
                  (ph_lane == sfc_pkg::LANE_2) ? 4'h3 : 4'h1;

  function automatic logic [7:0] addr_byte(input logic [31:0] a,
                                           input logic [5:0] idx,
                                           input logic [5:0] n);
    logic [5:0] sh;
    sh = n - idx;
    addr_byte = a[{sh[1:0], 3'b000} +: 8];
  endfunction

  always_comb
  begin
    cur_byte = txd_reg[7:0];
    if (in_op)
      cur_byte = op;
    else if (in_addr)
      cur_byte = addr_byte(addr_reg, byte_reg, addr_bytes);
    else if (in_mode)
      cur_byte = txd_reg[15:8];
  end

  sfc_lane_map u_map (
    .lane_i(ph_lane),
    .slot_i(slot_reg),
    .byte_i(cur_byte),
    .lanes_o(lanes)
  );

  // Divider tick for link clock half periods
  assign tick = (state_reg == SFC_RUN) && (div_reg == 8'(HALF - 1));
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I || state_reg != SFC_RUN || tick)
      div_reg <= 8'h00;
    else
      div_reg <= div_reg + 8'h01;
  end

  // Lanes reload one cycle after the link clock falls, once slot has moved
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      load_reg <= 1'b0;
    else
      load_reg <= (state_reg == SFC_IDLE && start_req) ||
                  (state_reg == SFC_RUN && tick && sck_reg);
  end

  // Sequencer, one byte at a time; data out changes one cycle after the falling edge
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      state_reg <= SFC_IDLE;
      sck_reg <= 1'b0;
      byte_reg <= 6'h00;
      slot_reg <= 3'h0;
      cnt_reg <= 8'h00;
      rxd_reg <= 32'h0;
      CS_B_O <= 1'b1;
      IO_O <= 4'h0;
      IO_OE_O <= 4'h0;
    end
    else
    begin
      case (state_reg)
        SFC_IDLE:
        begin
          if (start_req)
          begin
            state_reg <= SFC_RUN;
            CS_B_O <= 1'b0;
            byte_reg <= 6'h00;
            slot_reg <= 3'h0;
            cnt_reg <= 8'h00;
            sck_reg <= 1'b0;
          end
        end
        SFC_RUN:
        begin
          // Needs HALF of 2 or more so the lanes settle before the rise
          if (load_reg)
          begin
            IO_O <= lanes;
            IO_OE_O <= oe_val;
          end
          if (tick)
          begin
            sck_reg <= !sck_reg;
            if (!sck_reg && is_rd && !in_op && !in_addr && !in_mode)
            begin
              // Sample on rising edge, MSB first
              case (ph_lane)
                sfc_pkg::LANE_4: rxd_reg <= {rxd_reg[27:0], io_s2};
                sfc_pkg::LANE_2: rxd_reg <= {rxd_reg[29:0], io_s2[1:0]};
                default: rxd_reg <= {rxd_reg[30:0], io_s2[1]};
              endcase
            end
            if (sck_reg)
            begin
              if (slot_reg == slot_max)
              begin
                slot_reg <= 3'h0;
                if (in_dummy)
                  cnt_reg <= 8'h01;
                else if (!in_op && !in_addr && !in_mode)
                  cnt_reg <= cnt_reg + 8'h01;
                byte_reg <= byte_reg + 6'h01;
                if (last_byte)
                begin
                  // Host may stop a counter read at any byte
                  state_reg <= SFC_GAP;
                  CS_B_O <= 1'b1;
                  IO_OE_O <= 4'h0;
                end
              end
              else
                slot_reg <= slot_reg + 3'h1;
            end
          end
        end
        SFC_GAP:
          state_reg <= SFC_IDLE;
        default:
          state_reg <= SFC_IDLE;
      endcase
    end
  end

  assign SCK_O = sck_reg;

  // Mirror of the flash status word from the last status reads
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      flash_status_word <= sfc_pkg::STATUS_RESET;
    else if (state_reg == SFC_GAP && op == sfc_pkg::OP_STAT_LO)
      flash_status_word[7:0] <= rxd_reg[7:0];
    else if (state_reg == SFC_GAP && op == sfc_pkg::OP_STAT_HI)
      flash_status_word[15:8] <= rxd_reg[7:0];
  end
  // Software must issue the latch-set frame before modifying commands
  assign wlatch_ok = flash_status_word[sfc_pkg::ST_LATCH];

  // Register writes
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
    begin
      ctrl_reg <= 32'h0;
      addr_reg <= 32'h0;
      txd_reg <= 32'h0;
    end
    else if (WR_I && state_reg == SFC_IDLE)
    begin
      case (ADDR_I)
        sfc_pkg::R_CTRL: ctrl_reg <= WDATA_I;
        sfc_pkg::R_ADDR: addr_reg <= WDATA_I;
        sfc_pkg::R_TXDATA: txd_reg <= WDATA_I;
        default: ;
      endcase
    end
    else if (state_reg == SFC_RUN && tick && sck_reg &&
             slot_reg == slot_max && !in_op && !in_addr && !in_mode &&
             !in_dummy)
      txd_reg <= {8'h00, txd_reg[31:8]};
  end

  // Read port, data one cycle later; left to software polls
  always_ff @(posedge CLK_I)
  begin
    if (!RST_B_I)
      RDATA_O <= 32'h0;
    else if (RD_I)
    begin
      case (ADDR_I)
        sfc_pkg::R_CTRL: RDATA_O <= ctrl_reg;
        sfc_pkg::R_ADDR: RDATA_O <= addr_reg;
        sfc_pkg::R_TXDATA: RDATA_O <= txd_reg;
        sfc_pkg::R_RXDATA: RDATA_O <= rxd_reg;
        sfc_pkg::R_STATUS:
          RDATA_O <= {29'h0, wlatch_ok, counter_cmd, state_reg != SFC_IDLE};
        sfc_pkg::R_FLASH_ST: RDATA_O <= {16'h0, flash_status_word};
        default: RDATA_O <= 32'h0;
      endcase
    end
  end

  a_cs_idle: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    state_reg == SFC_IDLE |-> CS_B_O) else $error("cs low while idle");
  a_counter_lane: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (state_reg == SFC_RUN && counter_cmd) |-> IO_OE_O[3:1] == 3'h0)
    else $error("counter frame used extra lanes");
  a_sck_stop: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    CS_B_O |-> !SCK_O) else $error("clock active while deselected");
  a_lone_end: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    (state_reg == SFC_RUN && tick && sck_reg && slot_reg == slot_max &&
     in_op && lone_cmd) |=> (CS_B_O && state_reg == SFC_GAP))
    else $error("lone opcode frame ran on");
  a_oe_gap: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    state_reg == SFC_GAP |-> IO_OE_O == 4'h0)
    else $error("lanes still driven after deselect");
  a_sck_div: assert property (
    @(posedge CLK_I) disable iff (!RST_B_I)
    $changed(SCK_O) |-> $past(tick))
    else $error("link clock moved off divider tick");
  c_start: cover property (@(posedge CLK_I) $fell(CS_B_O));
  c_quad: cover property (@(posedge CLK_I) IO_OE_O == 4'hf);
  c_stat: cover property (@(posedge CLK_I) state_reg == SFC_GAP &&
    op == sfc_pkg::OP_STAT_LO);
endmodule

// ---- bench/sfc_flash_model.sv ----
// Behavioural serial flash answering latch and status commands
`timescale 1ns/10ps
module sfc_flash_model #(
  parameter logic [7:0] CNT_ST = 8'h5a
) (
  // Pins
  input wire logic cs_b_i,
  input wire logic sck_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o
);
  logic [15:0] st_reg;
  logic [7:0] sh;
  logic [7:0] op;
  int n;
  int k;
  // Lane captures for the bench, newest clock in the low bits
  logic [31:0] c1;
  logic [63:0] c2;
  logic [63:0] c4;
  // Nothing is ever busy or failed here
  initial
  begin
    st_reg = 16'h0000;
    io_o = 4'hd;
    sh = 8'h00;
    op = 8'h00;
    n = 0;
    c1 = 32'h0;
    c2 = 64'h0;
    c4 = 64'h0;
  end
  // Host may stop at any byte; count restarts on select
  always @(negedge cs_b_i) n = 0;
  always @(posedge sck_i)
    if (!cs_b_i)
    begin
      sh = {sh[6:0], io_i[0]};
      c1 = {c1[30:0], io_i[0]};
      c2 = {c2[61:0], io_i[1:0]};
      c4 = {c4[59:0], io_i};
      n = n + 1;
      if (n == 8) op = sh;
    end
  // Released lane toggles so a stale level never passes
  always @(negedge sck_i)
  begin
    k = n % 8;
    if (!cs_b_i && n >= 8 && op == 8'h05) io_o[1] = st_reg[7 - k];
    else if (!cs_b_i && n >= 8 && op == 8'h35) io_o[1] = st_reg[15 - k];
    else if (!cs_b_i && n >= 16 && op == 8'h96) io_o[1] = CNT_ST[7 - k];
    else io_o[1] = ~io_o[1];
  end
  // Only an opcode sent alone acts on the latch
  always @(posedge cs_b_i)
    if (n == 8)
    begin
      if (op == 8'h06) st_reg[1] = 1'b1;
      if (op == 8'h04) st_reg[1] = 1'b0;
      if (op == 8'h50) st_reg = st_reg;
    end
endmodule

// ---- bench/tb.sv ----
// Self-checking bench for the serial flash host controller
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    checks_done++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); \
    end \
  end
module tb;
  localparam logic [7:0] CST = 8'h5a;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic cs_b;
  logic sck;
  logic [3:0] io_in;
  logic [3:0] io_out;
  logic [3:0] io_oe;
  logic [3:0] mdl_io;
  logic [31:0] rx;
  logic upper_seen = 1'b0;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  assign io_in = (io_oe & io_out) | (~io_oe & mdl_io);
  sfc_host #(.HALF(4), .TXLEN(64)) u_sfc_host (.CLK_I(clk),
    .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .CS_B_O(cs_b), .SCK_O(sck),
    .IO_I(io_in), .IO_O(io_out), .IO_OE_O(io_oe));
  sfc_flash_model #(.CNT_ST(CST)) u_sfc_flash_model (.cs_b_i(cs_b),
    .sck_i(sck), .io_i(io_out), .io_o(mdl_io));
  always @(posedge clk)
    if (!cs_b && io_oe[3:1] != 3'h0) upper_seen <= 1'b1;
  task automatic tally_and_finish;
    $display("Checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      tally_and_finish;
    end
  end
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 400 && s[0] !== 1'b0; i++)
      reg_rd(sfc_pkg::R_STATUS, s);
    `CHK(s[0], 1'b0)
  endtask
  task automatic start(input logic [7:0] op, input logic [1:0] ln,
                       input logic r, input logic [6:0] dm);
    reg_wr(sfc_pkg::R_CTRL, {1'b1, dm, 1'b0, r, 4'h0, ln, 8'h00, op});
  endtask
  task automatic frame(input logic [7:0] op, input logic r);
    start(op, sfc_pkg::LANE_1, r, 7'h00);
    wait_idle;
    reg_rd(sfc_pkg::R_RXDATA, rx);
  endtask
  task automatic t_idle;
    logic [31:0] d;
    reg_wr(4'hf, 32'h8000_0006);
    reg_rd(4'hf, d);
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], sfc_pkg::STATUS_RESET[7:0])
    reg_rd(sfc_pkg::R_FLASH_ST, d);
    `CHK(d[7:0], 8'h00)
  endtask
  task automatic t_latch;
    frame(sfc_pkg::OP_LATCH_SET, 1'b0);
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], 8'h02)
    frame(sfc_pkg::OP_STAT_HI, 1'b1);
    `CHK(rx[7:0], 8'h00)
    frame(sfc_pkg::OP_LATCH_CLR, 1'b0);
    frame(sfc_pkg::OP_VOL_WRITE_LATCH_SET_CMD, 1'b0);
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], 8'h00)
  endtask
  task automatic t_refuse;
    start(sfc_pkg::OP_LATCH_SET, sfc_pkg::LANE_1, 1'b0, 7'h00);
    start(sfc_pkg::OP_LATCH_CLR, sfc_pkg::LANE_1, 1'b0, 7'h00);
    wait_idle;
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], 8'h02)
    frame(sfc_pkg::OP_LATCH_CLR, 1'b0);
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], 8'h00)
  endtask
  function automatic logic [31:0] cw(input logic [7:0] op,
                                     input logic [1:0] ln, input logic a4,
                                     input logic md, input logic four_wire_command_mode);
    cw = 32'h0;
    cw[sfc_pkg::C_START] = 1'b1;
    cw[sfc_pkg::C_ADDR_EN] = 1'b1;
    cw[sfc_pkg::C_ADDR4] = a4;
    cw[sfc_pkg::C_MODE_EN] = md;
    cw[sfc_pkg::C_QPI] = four_wire_command_mode;
    cw[sfc_pkg::C_LANE_LSB +: 2] = ln;
    cw[sfc_pkg::C_OP_LSB +: 8] = op;
  endfunction
  task automatic lane_frame(input logic [31:0] a, input logic [31:0] c);
    reg_wr(sfc_pkg::R_ADDR, a);
    reg_wr(sfc_pkg::R_TXDATA, 32'h0000_c3a5);
    reg_wr(sfc_pkg::R_CTRL, c);
    wait_idle;
  endtask
  task automatic t_lanes;
    logic [31:0] sa;
    sa = {16'h0000, sfc_pkg::SECREG2, 10'h155};
    lane_frame(sa, cw(8'ha2, sfc_pkg::LANE_2, 1'b0, 1'b0, 1'b0));
    `CHK(u_sfc_flash_model.c1[23:16], 8'ha2)
    `CHK(u_sfc_flash_model.c2[31:8], 24'h00_2155)
    `CHK(u_sfc_flash_model.c2[7:0], 8'ha5)
    lane_frame(sa, cw(8'h38, sfc_pkg::LANE_4, 1'b0, 1'b1, 1'b0));
    `CHK(u_sfc_flash_model.c1[17:10], 8'h38)
    `CHK(u_sfc_flash_model.c4[39:8], 32'h0021_55c3)
    `CHK(u_sfc_flash_model.c4[7:0], 8'ha5)
    lane_frame(32'h5a00_2155, cw(8'h12, sfc_pkg::LANE_4, 1'b1, 1'b0, 1'b1));
    `CHK(u_sfc_flash_model.c4[47:40], 8'h12)
    `CHK(u_sfc_flash_model.c4[39:0], 40'h5a_0021_55a5)
  endtask
  task automatic t_reset;
    start(sfc_pkg::OP_STAT_LO, sfc_pkg::LANE_1, 1'b1, 7'h00);
    repeat (20) @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    `CHK(cs_b, 1'b1)
    `CHK(sck, 1'b0)
    frame(sfc_pkg::OP_STAT_LO, 1'b1);
    `CHK(rx[7:0], 8'h00)
  endtask
  task automatic t_cnt;
    upper_seen = 1'b0;
    start(sfc_pkg::OP_CNT_READ, sfc_pkg::LANE_4, 1'b1, 7'h01);
    wait_idle;
    reg_rd(sfc_pkg::R_RXDATA, rx);
    `CHK(rx[7:0], CST)
    `CHK(upper_seen, 1'b0)
    `CHK(u_sfc_flash_model.op, sfc_pkg::OP_CNT_READ)
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    `CHK(rdata, 32'h0000_0000)
    `CHK(cs_b, 1'b1)
    t_idle;
    t_latch;
    t_refuse;
    t_lanes;
    t_cnt;
    t_reset;
    tally_and_finish;
  end
endmodule
